// [logic/can_msg_buffer_pkg.sv]
// package: register map, field layout and frame header types for the message buffer
package can_msg_buffer_pkg;

   // register indices on the plain register port
   localparam logic [3:0] IDR_HIGH_ADDR   = 4'h0; // standard_identifier_high_byte / ext id[28:21]
   localparam logic [3:0] IDR_LOW_ADDR    = 4'h1; // standard_identifier_low_bits / ext id[20:15],srr,ide
   localparam logic [3:0] IDR_EXT2_ADDR   = 4'h2; // ext id[14:7]
   localparam logic [3:0] IDR_EXT3_ADDR   = 4'h3; // extended_identifier_low_byte
   localparam logic [3:0] LEN_ADDR        = 4'h4; // length_code in bits 3:0
   localparam logic [3:0] CTRL_ADDR       = 4'h5; // bit0: buffer is transmit (1) or receive (0)
   localparam logic [3:0] STATUS_ADDR     = 4'h6; // bit0 frame received, bits 7:4 byte count

   // field positions
   localparam int EXT_RTR_BIT      = 0;
   localparam int STD_RTR_BIT      = 4;
   localparam int STD_IDE_BIT      = 3;
   localparam int EXT_IDE_BIT      = 3;
   localparam int EXT_SRR_BIT      = 4;

   localparam int STD_ID_W         = 11;
   localparam int EXT_ID_W         = 29;
   localparam int HEADER_W         = 32; // id(29) + rtr + ide + spare
   localparam int MAX_BYTES        = 8;
   localparam logic [3:0] MAX_LEN  = 4'h8;

   // frame header as it travels between buffer and bit engine
   typedef struct packed {
      logic [EXT_ID_W-1:0] id;     // standard ids sit in id[10:0]
      logic                extended_format_flag;
      logic                remote_request_flag;
      logic [3:0]          len;
   } frame_hdr_s;

   // serialiser states, gray along id -> rtr -> len
   typedef enum logic [1:0] {
      SER_IDLE = 2'b00,
      SER_ID   = 2'b01,
      SER_CTL  = 2'b11,
      SER_LEN  = 2'b10
   } ser_state_e;

endpackage : can_msg_buffer_pkg

// [logic/can_msg_buffer_id_dlc.sv]
// message buffer identifier / remote-request / length-code registers with header serialiser
//
// Summary of operation
// - extended id is 29 bits, msb first
// - smallest identifier wins arbitration within one format; standard beats extended
// - ext low byte: id[6:0], remote flag bit0
// - receive loads remote flag from frame
// - transmit sends remote flag: 0 data, 1 remote
// - standard id 11 bits, msb first, high byte
// - std low: id[2:0], remote, extended flag
// - length code 0..8 gives byte count
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module can_msg_buffer_id_dlc (
   input  wire logic                             clk_in,
   input  wire logic                             reset_n_in,
   input  wire logic [3:0]                       addr_in,
   input  wire logic [7:0]                       wdata_in,
   input  wire logic                             wr_in,
   input  wire logic                             rd_in,
   output logic      [7:0]                       rdata_out,
   input  wire logic                             rx_valid_in,
   input  wire can_msg_buffer_pkg::frame_hdr_s   rx_hdr_in,
   input  wire logic                             tx_start_in,
   input  wire logic [can_msg_buffer_pkg::EXT_ID_W-1:0] arb_id_in,
   input  wire logic                             arb_ide_in,
   output logic                                  tx_bit_out,
   output logic                                  tx_busy_out,
   output logic                                  tx_wins_out,
   output logic      [3:0]                       byte_count_out
);

   // ---------------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------------
   // codes above eight are clamped to eight bytes
   function automatic logic [3:0] len_to_bytes(input logic [3:0] len);
      len_to_bytes = (len > can_msg_buffer_pkg::MAX_LEN) ? can_msg_buffer_pkg::MAX_LEN : len;
   endfunction : len_to_bytes

   // ---------------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------------
   logic [7:0] idr_q [4];
   logic [7:0] idr_d [4];
   logic [3:0] len_q, len_d;
   logic       is_tx_q, is_tx_d;
   logic       rx_flag_q, rx_flag_d;
   logic [7:0] rdata_q, rdata_d;
   logic [3:0] bytes_q, bytes_d;

   // rx frame image laid out in register form
   logic [7:0] rx_img [4];
   always_comb begin
      rx_img[0] = 8'h00;
      rx_img[1] = 8'h00;
      rx_img[2] = 8'h00;
      rx_img[3] = 8'h00;
      if (rx_hdr_in.extended_format_flag) begin
         rx_img[0] = rx_hdr_in.id[28:21];
         rx_img[1] = {rx_hdr_in.id[20:18], 1'b1, 1'b1, rx_hdr_in.id[17:15]};
         rx_img[2] = rx_hdr_in.id[14:7];
         rx_img[3] = {rx_hdr_in.id[6:0], rx_hdr_in.remote_request_flag};
      end else begin
         rx_img[0] = rx_hdr_in.id[10:3];
         rx_img[1] = {rx_hdr_in.id[2:0], rx_hdr_in.remote_request_flag, 1'b0, 3'h0};
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         idr_d[i] = idr_q[i];
      end
      len_d     = len_q;
      is_tx_d   = is_tx_q;
      rx_flag_d = rx_flag_q;
      rdata_d   = 8'h00;
      if (wr_in) begin
         if (addr_in <= can_msg_buffer_pkg::IDR_EXT3_ADDR) begin
            idr_d[addr_in[1:0]] = wdata_in;
         end
         if (addr_in == can_msg_buffer_pkg::LEN_ADDR) begin
            len_d = wdata_in[3:0];
         end
         if (addr_in == can_msg_buffer_pkg::CTRL_ADDR) begin
            is_tx_d = wdata_in[0];
         end
         if (addr_in == can_msg_buffer_pkg::STATUS_ADDR && wdata_in[0]) begin
            rx_flag_d = 1'b0;
         end
      end
      // in receive mode a frame in the same cycle as a software write or clear wins
      if (rx_valid_in && !is_tx_q) begin
         for (int i = 0; i < 4; i++) begin
            idr_d[i] = rx_img[i];
         end
         len_d     = rx_hdr_in.len;
         rx_flag_d = 1'b1;
      end
      bytes_d = len_to_bytes(len_d);
      if (rd_in) begin
         case (addr_in)
            can_msg_buffer_pkg::IDR_HIGH_ADDR: rdata_d = idr_q[0];
            can_msg_buffer_pkg::IDR_LOW_ADDR:  rdata_d = idr_q[1];
            can_msg_buffer_pkg::IDR_EXT2_ADDR: rdata_d = idr_q[2];
            can_msg_buffer_pkg::IDR_EXT3_ADDR: rdata_d = idr_q[3];
            can_msg_buffer_pkg::LEN_ADDR:      rdata_d = {4'h0, len_q};
            can_msg_buffer_pkg::CTRL_ADDR:     rdata_d = {7'h00, is_tx_q};
            can_msg_buffer_pkg::STATUS_ADDR:   rdata_d = {bytes_q, 3'h0, rx_flag_q};
            default:                           rdata_d = 8'h00;
         endcase
      end
   end

   // id bytes have no reset value; cleared anyway so outputs are defined
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < 4; i++) begin
            idr_q[i] <= 8'h00;
         end
         len_q     <= 4'h0;
         is_tx_q   <= 1'b0;
         rx_flag_q <= 1'b0;
         rdata_q   <= 8'h00;
         bytes_q   <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            idr_q[i] <= idr_d[i];
         end
         len_q     <= len_d;
         is_tx_q   <= is_tx_d;
         rx_flag_q <= rx_flag_d;
         rdata_q   <= rdata_d;
         bytes_q   <= bytes_d;
      end
   end

   // ---------------------------------------------------------------------
   // decoded transmit header
   // ---------------------------------------------------------------------
   logic                                     ide_w;
   logic                                     rtr_w;
   logic [can_msg_buffer_pkg::EXT_ID_W-1:0]  id_w;
   always_comb begin
      ide_w = idr_q[1][can_msg_buffer_pkg::STD_IDE_BIT];
      if (ide_w) begin
         id_w  = {idr_q[0], idr_q[1][7:5], idr_q[1][2:0], idr_q[2], idr_q[3][7:1]};
         rtr_w = idr_q[3][can_msg_buffer_pkg::EXT_RTR_BIT];
      end else begin
         id_w  = {18'h00000, idr_q[0], idr_q[1][7:5]};
         rtr_w = idr_q[1][can_msg_buffer_pkg::STD_RTR_BIT];
      end
   end

   // ---------------------------------------------------------------------
   // header serialiser: id msb first, then rtr, then length code
   // ---------------------------------------------------------------------
   can_msg_buffer_pkg::ser_state_e st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic       bit_q, bit_d;
   logic       busy_q, busy_d;
   logic       wins_q, wins_d;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      bit_d  = 1'b1;
      busy_d = 1'b1;
      // lower id compares smaller; equal ids tie in our favour
      wins_d = (ide_w == arb_ide_in) ? (id_w <= arb_id_in) : !ide_w;
      case (st_q)
         can_msg_buffer_pkg::SER_IDLE: begin
            busy_d = 1'b0;
            if (tx_start_in && is_tx_q) begin
               st_d   = can_msg_buffer_pkg::SER_ID;
               cnt_d  = ide_w ? 5'(can_msg_buffer_pkg::EXT_ID_W - 1)
                              : 5'(can_msg_buffer_pkg::STD_ID_W - 1);
               busy_d = 1'b1;
            end
         end
         can_msg_buffer_pkg::SER_ID: begin
            bit_d = id_w[cnt_q];
            if (cnt_q == 5'h00) begin
               st_d = can_msg_buffer_pkg::SER_CTL;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         can_msg_buffer_pkg::SER_CTL: begin
            bit_d = rtr_w;
            st_d  = can_msg_buffer_pkg::SER_LEN;
            cnt_d = 5'h03;
         end
         can_msg_buffer_pkg::SER_LEN: begin
            bit_d = len_q[cnt_q[1:0]];
            if (cnt_q == 5'h00) begin
               st_d = can_msg_buffer_pkg::SER_IDLE;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         default: begin
            st_d = can_msg_buffer_pkg::SER_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q   <= can_msg_buffer_pkg::SER_IDLE;
         cnt_q  <= 5'h00;
         bit_q  <= 1'b1;
         busy_q <= 1'b0;
         wins_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         bit_q  <= bit_d;
         busy_q <= busy_d;
         wins_q <= wins_d;
      end
   end

   assign rdata_out      = rdata_q;
   assign tx_bit_out     = bit_q;
   assign tx_busy_out    = busy_q;
   assign tx_wins_out    = wins_q;
   assign byte_count_out = bytes_q;

endmodule : can_msg_buffer_id_dlc

`default_nettype wire

// [verif/can_id_checker.sv]
// checker: port-level properties of the identifier / length buffer
`timescale 1ns/1ps
`default_nettype none

module can_id_checker (
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic       rx_valid_in,
   input wire logic       tx_start_in,
   input wire logic [7:0] rdata_out,
   input wire logic       tx_bit_out,
   input wire logic       tx_busy_out,
   input wire logic [3:0] byte_count_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   AST_IDLE_RECESSIVE: assert property (!tx_busy_out |-> tx_bit_out)
      else $error("serial bit not recessive while idle");
   AST_RDATA_QUIET: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read slot");
   AST_UNMAPPED: assert property (rd_in && addr_in > 4'h6 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   AST_COUNT_MAX: assert property (byte_count_out <= 4'h8)
      else $error("byte count above eight");
   AST_LEN_DIRECT: assert property (wr_in && !rx_valid_in
      && addr_in == can_msg_buffer_pkg::LEN_ADDR && wdata_in[3:0] <= 4'h8
      |=> byte_count_out == $past(wdata_in[3:0]))
      else $error("byte count differs from length code");
   AST_LEN_CLAMP: assert property (wr_in && !rx_valid_in
      && addr_in == can_msg_buffer_pkg::LEN_ADDR && wdata_in[3:0] > 4'h8
      |=> byte_count_out == 4'h8)
      else $error("long length code not clamped");
   AST_START_CAUSE: assert property ($rose(tx_busy_out) |-> $past(tx_start_in))
      else $error("busy without start");
   AST_BUSY_MIN: assert property ($rose(tx_busy_out) |-> tx_busy_out [*8])
      else $error("header ended too early");
   AST_BUSY_END: assert property ($rose(tx_busy_out) |-> ##[17:35] !tx_busy_out)
      else $error("header length out of range");
endmodule : can_id_checker

bind can_msg_buffer_id_dlc can_id_checker u_chk (.clk_in, .reset_n_in, .addr_in, .wdata_in,
   .wr_in, .rd_in, .rx_valid_in, .tx_start_in, .rdata_out, .tx_bit_out, .tx_busy_out,
   .byte_count_out);
`default_nettype wire

// [verif/can_node_model.sv]
// partner: a remote bus node handing received frame headers to the buffer
`timescale 1ns/1ps
`default_nettype none

module can_node_model (
   input  wire logic                           clk_in,
   input  wire logic                           send_in,
   input  wire can_msg_buffer_pkg::frame_hdr_s hdr_in,
   output logic                                rx_valid_out,
   output can_msg_buffer_pkg::frame_hdr_s      rx_hdr_out
);
   // header only meaningful in the valid cycle; toggle otherwise so stale use shows
   initial begin
      rx_valid_out = 1'b0;
      rx_hdr_out   = '0;
      forever begin
         @(posedge clk_in);
         rx_valid_out <= send_in;
         rx_hdr_out   <= send_in ? hdr_in : ~rx_hdr_out;
      end
   end
endmodule : can_node_model
`default_nettype wire

// [verif/can_msg_buffer_id_dlc_tb_top.sv]
// testbench: registers, receive mapping, transmit order and priority against a model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
   $display("Error %s exp %h got %h", n, e, s); end end

module can_msg_buffer_id_dlc_tb_top;
   logic clk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, tx_start_in = 1'b0;
   logic send = 1'b0, arb_ide_in = 1'b0, rx_valid_in, tx_bit_out, tx_busy_out, tx_wins_out;
   logic [3:0]  addr_in = 4'h0, byte_count_out;
   logic [7:0]  wdata_in = 8'h00, rdata_out, rd_v;
   logic [28:0] arb_id_in = 29'h0;
   can_msg_buffer_pkg::frame_hdr_s hdr = '0, rx_hdr_in;
   int n_mismatch = 0, check_count = 0, seed = 6, id, remote_request_flag, len, ext, k, j, own;
   int q[$];

   can_msg_buffer_id_dlc u_dut (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .rx_valid_in, .rx_hdr_in, .tx_start_in, .arb_id_in, .arb_ide_in,
      .tx_bit_out, .tx_busy_out, .tx_wins_out, .byte_count_out);
   can_node_model u_node (.clk_in, .send_in(send), .hdr_in(hdr), .rx_valid_out(rx_valid_in),
      .rx_hdr_out(rx_hdr_in));

   initial forever #2.5 clk_in = ~clk_in;

   task automatic test_done;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   // gap cycle after each strobe so no strobe is driven twice in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in) wr_in <= 1'b0;
      @(posedge clk_in);
   endtask : wr

   task automatic rd(input logic [3:0] a);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in) rd_in <= 1'b0;
      @(negedge clk_in) rd_v = rdata_out;
      @(posedge clk_in);
   endtask : rd

   initial begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      test_done();
   end

   initial begin
      repeat (5) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      for (k = 0; k < 16; k++) if (k != 5 && k != 6) begin
         id = $random(seed);
         wr(k[3:0], id[7:0]);
         rd(k[3:0]);
         if (k == 4) `CHK("len", id[3:0], rd_v[3:0])
         else `CHK("reg", (k < 4) ? id[7:0] : 8'h00, rd_v)
      end
      for (k = 0; k < 16; k++) begin
         wr(can_msg_buffer_pkg::LEN_ADDR, k[7:0]);
         `CHK("count", 4'((k > 8) ? 8 : k), byte_count_out)
      end
      // receive: both formats, data and remote frames
      for (k = 0; k < 4; k++) begin
         ext = k % 2;
         remote_request_flag = k / 2;
         id = $random(seed);
         len = k + 7;
         hdr <= {ext ? id[28:0] : {18'h0, id[10:0]}, ext[0], remote_request_flag[0], len[3:0]};
         send <= 1'b1;
         @(posedge clk_in) send <= 1'b0;
         repeat (2) @(posedge clk_in);
         `CHK("count", 4'((len > 8) ? 8 : len), byte_count_out)
         rd(4'h0);
         `CHK("standard_identifier_high_byte", ext ? id[28:21] : id[10:3], rd_v)
         rd(4'h1);
         `CHK("standard_identifier_low_bits", {ext ? id[20:18] : id[2:0], ext[0]}, {rd_v[7:5], rd_v[3]})
         if (!ext) `CHK("rtr", remote_request_flag[0], rd_v[4])
         else begin
            `CHK("idr1x", {1'b1, id[17:15]}, {rd_v[4], rd_v[2:0]})
            rd(4'h2);
            `CHK("idr2", id[14:7], rd_v)
            rd(4'h3);
            `CHK("extended_identifier_low_byte", {id[6:0], remote_request_flag[0]}, rd_v)
         end
         // frame flag set with the count, then cleared by writing one
         rd(can_msg_buffer_pkg::STATUS_ADDR);
         `CHK("status", {4'((len > 8) ? 8 : len), 4'h1}, rd_v)
         wr(can_msg_buffer_pkg::STATUS_ADDR, 8'h01);
         rd(can_msg_buffer_pkg::STATUS_ADDR);
         `CHK("clear", 1'b0, rd_v[0])
      end
      // transmit: id msb first, request bit, length code; priority compare
      wr(can_msg_buffer_pkg::CTRL_ADDR, 8'h01);
      rd(can_msg_buffer_pkg::CTRL_ADDR);
      `CHK("ctrl", 8'h01, rd_v)
      for (k = 0; k < 4; k++) begin
         ext = k % 2;
         remote_request_flag = k / 2;
         id = ($random(seed) & 32'h0fff_fbff) | 32'h2;
         len = k + 5;
         own = ext ? id : id[10:0];
         if (ext) begin
            wr(4'h0, id[28:21]);
            wr(4'h1, {id[20:18], 2'b11, id[17:15]});
            wr(4'h2, id[14:7]);
            wr(4'h3, {id[6:0], remote_request_flag[0]});
         end else begin
            wr(4'h0, id[10:3]);
            wr(4'h1, {id[2:0], remote_request_flag[0], 4'h0});
         end
         wr(4'h4, len[7:0]);
         arb_ide_in <= ext[0];
         for (j = -1; j < 2; j++) begin
            arb_id_in <= 29'(own + j);
            repeat (2) @(posedge clk_in);
            `CHK("wins", j >= 0, tx_wins_out)
         end
         // mixed formats: the standard frame takes priority
         arb_ide_in <= ~ext[0];
         repeat (2) @(posedge clk_in);
         `CHK("wins_fmt", ext == 0, tx_wins_out)
         q = {};
         for (j = (ext ? 28 : 10); j >= 0; j--) q.push_back((own >> j) & 1);
         q.push_back(remote_request_flag);
         for (j = 3; j >= 0; j--) q.push_back((len >> j) & 1);
         tx_start_in <= 1'b1;
         @(posedge clk_in) tx_start_in <= 1'b0;
         @(negedge clk_in) `CHK("busy", 1'b1, tx_busy_out)
         for (j = 0; j < q.size(); j++) begin
            @(negedge clk_in) `CHK("bit", 1'(q[j]), tx_bit_out)
         end
         @(negedge clk_in) `CHK("busy", 1'b0, tx_busy_out)
         @(posedge clk_in);
      end
      // receive mode refuses a start
      wr(can_msg_buffer_pkg::CTRL_ADDR, 8'h00);
      tx_start_in <= 1'b1;
      @(posedge clk_in) tx_start_in <= 1'b0;
      @(negedge clk_in) `CHK("busy", 1'b0, tx_busy_out)
      test_done();
   end
endmodule : can_msg_buffer_id_dlc_tb_top
`default_nettype wire
